// ---- hdl/ssr_pkg.sv ----
// Notes on behaviour
// - Strobe rise starts conversion, internally timed.
// - Data output floats while strobe high.
// - Strobe fall enables output, shows MSB.
// - Strobe fall starts sampling next input.
// - Next 13 bits on clock falling edges.
// - Most significant bit first, LSB last.
// - Fourteen bits, then zeros without limit.
// - Output is this conversion, no latency.
// - Nap entered automatically after each conversion.
// - Two strobe pulses, clock static: nap.
// - Four strobe pulses, clock static: sleep.
// - Sleep turns off bias, bandgap, reference.
// - Nap keeps bandgap and reference powered.
// - One serial clock pulse wakes device.
package ssr_pkg;

  // Widths and buffer depth
  localparam int RES_W = 14;
  localparam int FIFO_DEPTH = 16;

  // Conversion time from the internal oscillator, rounded up to clock cycles
  localparam int CLK_PERIOD_NS = 25;
  localparam int CONVERT_STROBE_TIME_NS = 225;
  localparam int CONVERT_STROBE_CYC = (CONVERT_STROBE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [3:0] CONVERT_STROBE_CNT_LOAD = 4'(CONVERT_STROBE_CYC - 1);

  // Strobe pulse counts that select a power-down mode
  localparam logic [2:0] NAP_PULSES = 3'h2;
  localparam logic [2:0] SLEEP_PULSES = 3'h4;
  localparam logic [2:0] PULSE_MAX = 3'h7;

  // Power states, one-hot
  typedef enum logic [2:0] {
    PWR_ACTIVE = 3'h1,
    PWR_NAP = 3'h2,
    PWR_SLEEP = 3'h4
  } ssr_pwr_t;

  // Reset values
  localparam ssr_pwr_t PWR_RESET = PWR_NAP;
  localparam logic [RES_W-1:0] SHIFT_RESET = 14'h0000;

  // Pin levels from the host
  typedef struct packed {
    logic convert_strobe;
    logic sck;
  } ssr_pins_t;

  // Analog power and track controls
  typedef struct packed {
    logic core_on;
    logic ref_on;
    logic bias_on;
    logic sample;
  } ssr_power_t;

endpackage

// ---- hdl/ssr_readout.sv ----
`timescale 1ns/1ps
`default_nettype none

// Result buffer between the conversion engine and the shifter
module ssr_fifo #(
  parameter int WIDTH = 14,
  parameter int DEPTH = 16
) (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW:0] wptr_q;
  logic [AW:0] rptr_q;
  logic push;
  logic pop;

  // Full when pointers differ only in the wrap bit
  assign in_ready_o = !((wptr_q[AW] != rptr_q[AW]) && (wptr_q[AW-1:0] == rptr_q[AW-1:0]));
  assign out_valid_o = (wptr_q != rptr_q);
  assign push = in_valid_i && in_ready_o;
  assign pop = out_valid_o && out_ready_i;
  assign out_data_o = mem_q[rptr_q[AW-1:0]];

  // Storage
  always_ff @(posedge clk_i) begin
    if (push) begin
      mem_q[wptr_q[AW-1:0]] <= in_data_i;
    end
  end

  // Write pointer
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      wptr_q <= '0;
    end else if (push) begin
      wptr_q <= wptr_q + 1'b1;
    end
  end

  // Read pointer
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      rptr_q <= '0;
    end else if (pop) begin
      rptr_q <= rptr_q + 1'b1;
    end
  end

endmodule // ssr_fifo

// Digital side of the serial sampling converter
module ssr_readout import ssr_pkg::*; (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire ssr_pins_t pins_i,
  input wire logic [RES_W-1:0] adc_code_i,
  output logic sdo_o,
  output logic sdo_oe_o,
  output ssr_power_t power_o,
  output logic convert_strobe_busy_o
);

  ssr_pins_t s1_q;
  ssr_pins_t s2_q;
  ssr_pins_t s3_q;
  logic convert_strobe_rise;
  logic convert_strobe_fall;
  logic sck_rise;
  logic sck_fall;
  logic sck_edge;
  logic busy_q;
  logic [3:0] cnt_q;
  logic convert_strobe_done;
  logic f_in_ready;
  logic f_out_valid;
  logic f_pop;
  logic [RES_W-1:0] f_out_data;
  logic [RES_W-1:0] shift_q;
  logic oe_q;
  logic [2:0] pulses_q;
  ssr_pwr_t pwr_q;
  ssr_pwr_t pwr_d;
  logic sample_q;

  // Two-stage synchronisers for both pins, plus an edge stage
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
    end else begin
      s1_q <= pins_i;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // Edge detection on the synchronised levels
  assign convert_strobe_rise = s2_q.convert_strobe && !s3_q.convert_strobe;
  assign convert_strobe_fall = !s2_q.convert_strobe && s3_q.convert_strobe;
  assign sck_rise = s2_q.sck && !s3_q.sck;
  assign sck_fall = !s2_q.sck && s3_q.sck;
  assign sck_edge = sck_rise || sck_fall;

  // Conversion timer, run by the internal clock, never by the serial clock
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      busy_q <= 1'b0;
      cnt_q <= '0;
    end else if (convert_strobe_rise && pwr_q != PWR_SLEEP) begin
      busy_q <= 1'b1;
      cnt_q <= CONVERT_STROBE_CNT_LOAD;
    end else if (busy_q && !s2_q.convert_strobe) begin
      busy_q <= 1'b0; // Strobe dropped early: conversion abandoned
    end else if (busy_q && cnt_q != 4'h0) begin
      cnt_q <= cnt_q - 4'h1;
    end else if (convert_strobe_done) begin
      busy_q <= 1'b0;
    end
  end

  // Result is handed over only when the buffer can take it
  assign convert_strobe_done = busy_q && s2_q.convert_strobe && (cnt_q == 4'h0) && f_in_ready;
  assign convert_strobe_busy_o = busy_q;

  // Shifter takes the word at the strobe fall
  assign f_pop = convert_strobe_fall;

  ssr_fifo #(
    .WIDTH(RES_W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk_i(clk_i),
    .rstn_i(rstn_i),
    .in_valid_i(convert_strobe_done),
    .in_ready_o(f_in_ready),
    .in_data_i(adc_code_i),
    .out_valid_o(f_out_valid),
    .out_ready_i(f_pop),
    .out_data_o(f_out_data)
  );

  // Output enable: off while strobe high, on from its fall
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      oe_q <= 1'b0;
    end else if (s2_q.convert_strobe) begin
      oe_q <= 1'b0;
    end else if (convert_strobe_fall) begin
      oe_q <= 1'b1;
    end
  end

  // Shift register, MSB first, zeros fill in behind
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      shift_q <= SHIFT_RESET;
    end else if (convert_strobe_fall) begin
      shift_q <= f_out_valid ? f_out_data : SHIFT_RESET;
    end else if (sck_fall && oe_q) begin
      shift_q <= {shift_q[RES_W-2:0], 1'b0};
    end
  end

  assign sdo_o = shift_q[RES_W-1];
  assign sdo_oe_o = oe_q;

  // Track mode from strobe fall, hold from strobe rise
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      sample_q <= 1'b1;
    end else if (convert_strobe_fall) begin
      sample_q <= 1'b1;
    end else if (convert_strobe_rise) begin
      sample_q <= 1'b0;
    end
  end

  // Strobe pulses counted while the serial clock stays still
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      pulses_q <= '0;
    end else if (sck_edge) begin
      pulses_q <= '0;
    end else if (convert_strobe_rise && pulses_q != PULSE_MAX) begin
      pulses_q <= pulses_q + 3'h1;
    end
  end

  // Power state choice
  always_comb begin
    pwr_d = pwr_q;
    case (pwr_q)
      PWR_ACTIVE: begin
        if (convert_strobe_fall && pulses_q == SLEEP_PULSES) begin
          pwr_d = PWR_SLEEP;
        end else if (convert_strobe_fall && pulses_q == NAP_PULSES) begin
          pwr_d = PWR_NAP;
        end else if (convert_strobe_done) begin
          pwr_d = PWR_NAP;
        end
      end
      PWR_NAP: begin
        if (convert_strobe_fall && pulses_q == SLEEP_PULSES) begin
          pwr_d = PWR_SLEEP;
        end else if (sck_edge || convert_strobe_rise) begin
          pwr_d = PWR_ACTIVE;
        end
      end
      PWR_SLEEP: begin
        if (sck_edge) begin
          pwr_d = PWR_ACTIVE;
        end
      end
      default: begin
        pwr_d = PWR_RESET;
      end
    endcase
  end

  // Power state register
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      pwr_q <= PWR_RESET;
    end else begin
      pwr_q <= pwr_d;
    end
  end

  // Analog controls; bandgap and reference stay up except in sleep
  assign power_o.core_on = (pwr_q == PWR_ACTIVE);
  assign power_o.ref_on = (pwr_q != PWR_SLEEP);
  assign power_o.bias_on = (pwr_q != PWR_SLEEP);
  assign power_o.sample = sample_q;

  // Checker helper: word handed over at the end of a conversion, and whether
  // the shifter has yet to take it; the result path through the buffer is not reused
  logic [RES_W-1:0] chk_word_q;
  logic chk_fresh_q;
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      chk_word_q <= SHIFT_RESET;
      chk_fresh_q <= 1'b0;
    end else if (convert_strobe_done) begin
      chk_word_q <= adc_code_i;
      chk_fresh_q <= 1'b1;
    end else if (convert_strobe_fall) begin
      chk_fresh_q <= 1'b0;
    end
  end

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rstn_i);

  // Output floats while the strobe stays high
  a_sdo_float_high: assert property (s2_q.convert_strobe && s3_q.convert_strobe |-> !sdo_oe_o)
    else $error("data output driven while strobe high");

  // MSB of the buffered word appears at strobe fall
  a_fall_msb_out: assert property (convert_strobe_fall && f_out_valid |=> sdo_oe_o && sdo_o == $past(f_out_data[RES_W-1]))
    else $error("MSB not presented at strobe fall");

  // Each serial clock fall moves the next bit out
  a_sck_shift_bit: assert property (sck_fall && oe_q && !convert_strobe_fall && !s2_q.convert_strobe |=> sdo_o == $past(shift_q[RES_W-2]))
    else $error("serial clock fall did not shift next bit");

  // After the last bit only zeros remain
  a_zero_fill_tail: assert property (oe_q && shift_q == SHIFT_RESET && !convert_strobe_fall |=> sdo_o == 1'b0)
    else $error("non-zero bit after result");

  // Word popped at fall is the word just converted
  a_same_convert_strobe_word: assert property (convert_strobe_fall && chk_fresh_q |=> shift_q == chk_word_q)
    else $error("shifted word not from last conversion");

  // Conversion ends exactly nine cycles after the rise is seen, never earlier
  a_convert_strobe_timing: assert property (convert_strobe_rise && pwr_q != PWR_SLEEP
      ##1 (s2_q.convert_strobe && !convert_strobe_done)[*8] ##1 (s2_q.convert_strobe && f_in_ready) |-> convert_strobe_done)
    else $error("conversion length wrong");

  // A strobe that drops during the count abandons the conversion
  a_early_abort: assert property (busy_q && !s2_q.convert_strobe |=> !convert_strobe_busy_o)
    else $error("conversion kept running after strobe fall");

  // Sampling begins at the strobe fall
  a_fall_sampling: assert property (convert_strobe_fall |=> power_o.sample)
    else $error("sample mode not entered at strobe fall");

  // Nap follows a completed conversion
  a_auto_nap_entry: assert property (convert_strobe_done && pwr_q == PWR_ACTIVE && !convert_strobe_fall |=> pwr_q == PWR_NAP)
    else $error("no nap after conversion");

  // Two static-clock pulses put the device into nap
  a_two_pulse_nap: assert property (convert_strobe_fall && pulses_q == NAP_PULSES && pwr_q == PWR_ACTIVE |=> pwr_q == PWR_NAP)
    else $error("two pulses did not give nap");

  // Four static-clock pulses put the device into sleep with bias off
  a_four_pulse_sleep: assert property (convert_strobe_fall && pulses_q == SLEEP_PULSES && pwr_q != PWR_SLEEP
      |=> pwr_q == PWR_SLEEP && !power_o.bias_on && !power_o.ref_on)
    else $error("four pulses did not give sleep");

  // Nap keeps the reference alive
  a_nap_ref_kept: assert property (pwr_q == PWR_NAP |-> power_o.ref_on && power_o.bias_on && !power_o.core_on)
    else $error("reference off during nap");

  // One serial clock edge wakes from nap or sleep
  a_sck_wakeup: assert property (sck_edge && pwr_q != PWR_ACTIVE && !convert_strobe_fall |=> pwr_q == PWR_ACTIVE)
    else $error("serial clock did not wake device");

  // Only a serial clock edge leaves sleep
  a_sleep_holds: assert property (pwr_q == PWR_SLEEP && !sck_edge |=> pwr_q == PWR_SLEEP)
    else $error("sleep left without serial clock");

  // No conversion starts while the bias is off
  a_sleep_no_convert_strobe: assert property (convert_strobe_rise && pwr_q == PWR_SLEEP |=> !convert_strobe_busy_o)
    else $error("conversion started in sleep");

  // Any serial clock edge restarts the pulse count
  a_pulse_clear: assert property (sck_edge |=> pulses_q == 3'h0)
    else $error("pulse count not cleared by serial clock");

  // Output stays enabled until the strobe rises again
  a_oe_until_rise: assert property (sdo_oe_o && !s2_q.convert_strobe |=> sdo_oe_o)
    else $error("data output released while strobe low");

  // Main scenarios
  c_full_frame: cover property (convert_strobe_fall ##[1:100] (sck_fall && oe_q));
  c_nap_by_pulses: cover property (convert_strobe_fall && pulses_q == NAP_PULSES && pwr_q == PWR_ACTIVE);
  c_enter_sleep: cover property (pwr_q == PWR_ACTIVE ##1 pwr_q == PWR_SLEEP);
  c_wake_sleep: cover property (pwr_q == PWR_SLEEP ##1 pwr_q == PWR_ACTIVE);
  c_convert_strobe_done: cover property (convert_strobe_done);

endmodule // ssr_readout

`default_nettype wire

// ---- verification/ssr_host_model.sv ----
`timescale 1ns/1ps
`default_nettype none

// Host controller: drives strobe and serial clock, samples the data line
module ssr_host_model import ssr_pkg::*; (
  input wire logic clk_i,
  input wire logic sdo_i,
  output ssr_pins_t pins_o
);
  localparam int SLEEP_WAKE_CYC = 44000;

  // Pins idle low from time zero
  initial begin
    pins_o = '0;
  end

  // All pin moves land on falling clock edges
  task automatic wait_cyc(input int n);
    repeat (n) @(negedge clk_i);
  endtask

  // Serial clock is left static while the strobe is high
  task automatic convert_strobe_rise();
    pins_o.convert_strobe = 1'b1;
  endtask

  // Strobe drops, then four cycles pass before the next pin move
  task automatic convert_strobe_fall();
    pins_o.convert_strobe = 1'b0;
    wait_cyc(4);
  endtask

  // Full strobe pulse with the serial clock static
  task automatic convert_strobe_pulse();
    convert_strobe_rise();
    wait_cyc(20);
    convert_strobe_fall();
  endtask

  // Brief strobe pulse for mode entry; drops before the conversion ends
  task automatic mode_pulse();
    convert_strobe_rise();
    wait_cyc(4);
    convert_strobe_fall();
  endtask

  // One serial clock period of 200 ns, well under the top rate
  task automatic sck_pulse();
    pins_o.sck = 1'b1;
    wait_cyc(4);
    pins_o.sck = 1'b0;
    wait_cyc(4);
  endtask

  // Keeps exactly the result bits, the trailing bits go apart
  task automatic read_frame(output logic [RES_W-1:0] code, output logic [1:0] tail);
    code = '0;
    tail = '0;
    for (int i = 0; i < RES_W + 2; i++) begin
      if (i > 0) begin
        sck_pulse();
      end
      if (i < RES_W) begin
        code = {code[RES_W-2:0], sdo_i};
      end else begin
        tail = {tail[0], sdo_i};
      end
    end
  endtask

  // Single clock pulse wakes; allow the short nap power-up time
  task automatic wake_nap();
    sck_pulse();
    wait_cyc(2);
  endtask

  // Reference must recharge after sleep before a conversion
  task automatic settle_sleep();
    wait_cyc(SLEEP_WAKE_CYC);
  endtask
endmodule // ssr_host_model

`default_nettype wire

// ---- verification/test_ssr_readout.sv ----
`timescale 1ns/1ps
`default_nettype none

// Self-checking bench for the converter readout
module test_ssr_readout import ssr_pkg::*; ;
  logic clk_i;
  logic rstn_i;
  logic [RES_W-1:0] adc_code;
  logic sdo;
  logic sdo_oe;
  logic busy;
  ssr_pins_t pins;
  ssr_power_t pwr;
  wire sdo_line;
  int fail_count = 0;
  int n_compared = 0;

  // Data line floats when the output is not enabled
  assign sdo_line = sdo_oe ? sdo : 1'bz;

  // 40 MHz clock
  initial begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end

  ssr_readout u_dut (.clk_i(clk_i), .rstn_i(rstn_i), .pins_i(pins), .adc_code_i(adc_code),
    .sdo_o(sdo), .sdo_oe_o(sdo_oe), .power_o(pwr), .convert_strobe_busy_o(busy));

  ssr_host_model u_host (.clk_i(clk_i), .sdo_i(sdo_line), .pins_o(pins));

  // Compare and count
  task automatic check(input logic [RES_W-1:0] seen, input logic [RES_W-1:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fail_count++;
      $display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask

  task automatic tally_and_finish();
    $display("Compared %0d, mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // Power-up state after reset
  task automatic s_reset();
    check(14'(sdo_oe), 14'h0000);
    check(14'(busy), 14'h0000);
    check(14'(pwr), 14'h0007);
  endtask

  // One conversion and a read with two extra clocks
  task automatic s_frame(input logic [RES_W-1:0] code);
    logic [RES_W-1:0] got;
    logic [1:0] tail;
    adc_code = code;
    u_host.convert_strobe_rise();
    u_host.wait_cyc(4);
    check(14'(sdo_oe), 14'h0000);
    check(14'(pwr.sample), 14'h0000);
    u_host.wait_cyc(6);
    check(14'(busy), 14'h0001);
    u_host.wait_cyc(6);
    check(14'(busy), 14'h0000);
    check(14'(pwr.core_on), 14'h0000);
    check(14'(sdo_oe), 14'h0000);
    adc_code = ~code;
    u_host.wait_cyc(4);
    u_host.convert_strobe_fall();
    check(14'(sdo_oe), 14'h0001);
    check(14'(pwr.sample), 14'h0001);
    u_host.read_frame(got, tail);
    check(got, code);
    check(14'(tail), 14'h0000);
  endtask

  // Two strobe pulses, then a one-pulse wake and a prompt conversion
  task automatic s_nap();
    u_host.mode_pulse();
    u_host.mode_pulse();
    check(14'(pwr), 14'h0007);
    u_host.wake_nap();
    check(14'(pwr.core_on), 14'h0001);
    s_frame(14'h1555);
  endtask

  // Four strobe pulses, strobe ignored in sleep, clock pulse wakes
  task automatic s_sleep();
    repeat (4) u_host.convert_strobe_pulse();
    check(14'(pwr), 14'h0001);
    u_host.convert_strobe_rise();
    u_host.wait_cyc(10);
    check(14'(busy), 14'h0000);
    u_host.convert_strobe_fall();
    check(14'(pwr.ref_on), 14'h0000);
    u_host.sck_pulse();
    check(14'(pwr), 14'h000F);
    u_host.settle_sleep();
    s_frame(14'h2A5C);
  endtask

  // Reset in the middle of a conversion clears it
  task automatic s_midreset();
    u_host.convert_strobe_rise();
    u_host.wait_cyc(6);
    check(14'(busy), 14'h0001);
    rstn_i = 1'b0;
    u_host.convert_strobe_fall();
    rstn_i = 1'b1;
    u_host.wait_cyc(3);
    s_reset();
  endtask

  // Main sequence
  initial begin
    rstn_i = 1'b0;
    adc_code = 14'h0000;
    repeat (5) @(negedge clk_i);
    rstn_i = 1'b1;
    u_host.wait_cyc(3);
    s_reset();
    s_frame(14'h3FFF);
    s_frame(14'h0001);
    s_frame(14'h2000);
    s_midreset();
    s_nap();
    s_sleep();
    tally_and_finish();
  end
endmodule // test_ssr_readout

`default_nettype wire
